// File: cocr_map.vh
// constants of the converter output configuration bank: command codes, word
// indices, field positions, reset values and timing figures.
// assumes a 250 MHz system clock and a host transaction layer outside.
`ifndef COCR_MAP_VH
`define COCR_MAP_VH

// ***************************************************************
// command codes
// ***************************************************************
`define CODE_MARGIN_HIGH 8'h25
`define CODE_MARGIN_LOW 8'h26
`define CODE_SLEW 8'h27
`define CODE_LOAD_LINE 8'h28
`define CODE_FLOOR 8'h2B
`define CODE_DUTY 8'h32
`define CODE_FREQ 8'h33
`define CODE_TURN_ON 8'h35
`define CODE_TURN_OFF 8'h36
`define CODE_INTERLEAVE 8'h37
`define CODE_IOUT_OFS 8'h39
`define CODE_OV_LIMIT 8'h40

// ***************************************************************
// word indices inside the bank
// ***************************************************************
`define IDX_MARGIN_HIGH 4'h0
`define IDX_MARGIN_LOW 4'h1
`define IDX_SLEW 4'h2
`define IDX_LOAD_LINE 4'h3
`define IDX_FLOOR 4'h4
`define IDX_DUTY 4'h5
`define IDX_FREQ 4'h6
`define IDX_TURN_ON 4'h7
`define IDX_TURN_OFF 4'h8
`define IDX_INTERLEAVE 4'h9
`define IDX_IOUT_OFS 4'hA
`define IDX_OV_LIMIT 4'hB
`define NUM_WORDS 12

// ***************************************************************
// fields
// ***************************************************************
`define LIN_EXP_HI 15
`define LIN_EXP_LO 11
`define LIN_MANT_HI 10
`define MODE_SEL_HI 7
`define MODE_SEL_LO 5
`define MODE_EXP_HI 4
`define MODE_SEL_LINEAR 3'h0
`define MODE_EXP_FIXED 5'h15
`define IL_GROUP_HI 11
`define IL_GROUP_LO 8
`define IL_COUNT_HI 7
`define IL_COUNT_LO 4
`define IL_POS_HI 3
`define IL_POS_LO 0
`define MARGIN_HIGH_SEL 2'h1
`define MARGIN_LOW_SEL 2'h2

// ***************************************************************
// reset values and number formats
// ***************************************************************
`define WORD_RESET 16'h0000
`define FIX_W 40
`define LIN_FRAC 8
`define SLEW_LSB_PER_VOLT 2048
`define PHASE_STEPS 256

// ***************************************************************
// timing
// ***************************************************************
`define CLK_PERIOD_PS 4000
`define RATE_TIME_PS 1000000000
`define CYC_PER_RATE_TIME (`RATE_TIME_PS / `CLK_PERIOD_PS)

`endif

// File: cocr_regbank.v
// storage of the configuration words: one write port, one registered read
// port, and every word laid out flat for the control logic.
// assumes write and read requests are synchronous to CLK.
`timescale 1ns/10ps
`include "cocr_map.vh"

module cocr_regbank #(
    parameter DW = 16,
    parameter DEPTH = `NUM_WORDS,
    parameter AW = 4
) (
    input wire CLK,
    input wire RSTN,
    input wire WE,
    input wire [AW-1:0] WADDR,
    input wire [DW-1:0] WDATA,
    input wire [AW-1:0] RADDR,
    output reg [DW-1:0] RDATA,
    output wire [DW*DEPTH-1:0] WORDS
);
    reg [DW*DEPTH-1:0] mem_reg;
    integer i;

    assign WORDS = mem_reg;

    always @(posedge CLK) begin
        if (!RSTN) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_reg[i*DW +: DW] <= `WORD_RESET;
            end
            RDATA <= {DW{1'b0}};
        end else begin
            if (WE) begin
                mem_reg[WADDR*DW +: DW] <= WDATA;
            end
            // read after write of the same word returns the old value
            RDATA <= mem_reg[RADDR*DW +: DW];
        end
    end
endmodule

// File: cocr_top.v
// converter output configuration bank: command-coded register access and the
// setpoint, threshold, interleave, current offset and overvoltage logic.
// assumes the transaction layer delivers decoded command codes and data words.
`timescale 1ns/10ps
`include "cocr_map.vh"

module cocr_top #(
    parameter DW = 16,
    parameter FW = `FIX_W
) (
    input wire CLK,
    input wire RSTN,
    input wire [7:0] CMD_CODE,
    input wire [DW-1:0] WR_DATA,
    input wire WR_STB,
    input wire RD_STB,
    output reg [DW-1:0] RD_DATA,
    output wire RD_VALID,
    output wire CMD_UNSUP,
    input wire [7:0] OUT_MODE,
    input wire [DW-1:0] NOMINAL_CMD,
    input wire [DW-1:0] TRIM_CMD,
    input wire [1:0] MARGIN_SEL,
    input wire [DW-1:0] MEAS_VIN,
    input wire [DW-1:0] MEAS_VOUT,
    input wire [DW-1:0] IOUT_RAW,
    input wire SYNC_LOCKED,
    input wire CLR_WARN,
    output reg [DW-1:0] VOUT_SETPOINT,
    output reg [DW-1:0] VOUT_TARGET,
    output reg FLOOR_WARN,
    output reg MODE_ERR,
    output reg CONVERT_EN,
    output reg OV_FAULT,
    output reg [31:0] IOUT_REPORT,
    output reg [31:0] LOAD_LINE_Q8,
    output reg [31:0] DUTY_MAX_Q8,
    output reg [DW-1:0] FREQ_KHZ,
    output reg [3:0] GROUP_ID,
    output reg [3:0] GROUP_SIZE,
    output reg [3:0] RAIL_POS,
    output reg INTERLEAVE_EN,
    output reg [7:0] PHASE_OFFSET
);
    // ***************************************************************
    // functions
    // ***************************************************************
    // returns {known, index} for a command code
    function [4:0] code_index;
        input [7:0] code;
        begin
            case (code)
                `CODE_MARGIN_HIGH: code_index = {1'b1, `IDX_MARGIN_HIGH};
                `CODE_MARGIN_LOW: code_index = {1'b1, `IDX_MARGIN_LOW};
                `CODE_SLEW: code_index = {1'b1, `IDX_SLEW};
                `CODE_LOAD_LINE: code_index = {1'b1, `IDX_LOAD_LINE};
                `CODE_FLOOR: code_index = {1'b1, `IDX_FLOOR};
                `CODE_DUTY: code_index = {1'b1, `IDX_DUTY};
                `CODE_FREQ: code_index = {1'b1, `IDX_FREQ};
                `CODE_TURN_ON: code_index = {1'b1, `IDX_TURN_ON};
                `CODE_TURN_OFF: code_index = {1'b1, `IDX_TURN_OFF};
                `CODE_INTERLEAVE: code_index = {1'b1, `IDX_INTERLEAVE};
                `CODE_IOUT_OFS: code_index = {1'b1, `IDX_IOUT_OFS};
                `CODE_OV_LIMIT: code_index = {1'b1, `IDX_OV_LIMIT};
                default: code_index = 5'h00;
            endcase
        end
    endfunction

    // linear word to signed fixed point with LIN_FRAC fraction bits
    function [FW-1:0] lin_fix;
        input [15:0] v;
        reg signed [FW-1:0] m;
        reg signed [6:0] sh;
        reg [6:0] mag;
        begin
            m = {{(FW-11){v[`LIN_MANT_HI]}}, v[`LIN_MANT_HI:0]};
            sh = {{2{v[`LIN_EXP_HI]}}, v[`LIN_EXP_HI:`LIN_EXP_LO]} + 7'sd`LIN_FRAC;
            mag = -sh;
            if (sh[6]) begin
                lin_fix = m >>> mag;
            end else begin
                lin_fix = m <<< sh;
            end
        end
    endfunction

    function [DW-1:0] word_at;
        input [DW*`NUM_WORDS-1:0] flat;
        input [3:0] idx;
        begin
            word_at = flat[idx*DW +: DW];
        end
    endfunction

    // ***************************************************************
    // register access
    // ***************************************************************
    wire [4:0] dec = code_index(CMD_CODE);
    wire [DW*`NUM_WORDS-1:0] words;
    wire [DW-1:0] bank_rdata;
    reg rd_pend_reg;
    reg rd_known_reg;

    cocr_regbank #(
        .DW(DW),
        .DEPTH(`NUM_WORDS),
        .AW(4)
    ) u_bank (
        .CLK(CLK),
        .RSTN(RSTN),
        .WE(WR_STB & dec[4]),
        .WADDR(dec[3:0]),
        .WDATA(WR_DATA),
        .RADDR(dec[3:0]),
        .RDATA(bank_rdata),
        .WORDS(words)
    );

    // unknown codes are refused at once; writes to them change nothing
    assign CMD_UNSUP = (WR_STB | RD_STB) & ~dec[4];
    assign RD_VALID = rd_pend_reg;

    always @(posedge CLK) begin
        if (!RSTN) begin
            rd_pend_reg <= 1'b0;
            rd_known_reg <= 1'b0;
        end else begin
            rd_pend_reg <= RD_STB;
            rd_known_reg <= dec[4];
        end
    end

    always @* begin
        RD_DATA = rd_known_reg ? bank_rdata : {DW{1'b0}};
    end

    wire [DW-1:0] w_mhigh = word_at(words, `IDX_MARGIN_HIGH);
    wire [DW-1:0] w_mlow = word_at(words, `IDX_MARGIN_LOW);
    wire [DW-1:0] w_slew = word_at(words, `IDX_SLEW);
    wire [DW-1:0] w_droop = word_at(words, `IDX_LOAD_LINE);
    wire [DW-1:0] w_floor = word_at(words, `IDX_FLOOR);
    wire [DW-1:0] w_duty = word_at(words, `IDX_DUTY);
    wire [DW-1:0] w_freq = word_at(words, `IDX_FREQ);
    wire [DW-1:0] w_von = word_at(words, `IDX_TURN_ON);
    wire [DW-1:0] w_voff = word_at(words, `IDX_TURN_OFF);
    wire [DW-1:0] w_il = word_at(words, `IDX_INTERLEAVE);
    wire [DW-1:0] w_iofs = word_at(words, `IDX_IOUT_OFS);
    wire [DW-1:0] w_ovl = word_at(words, `IDX_OV_LIMIT);

    // ***************************************************************
    // output target and floor clamp
    // ***************************************************************
    // all output-mode words share exponent minus eleven, so raw compares hold
    reg [DW-1:0] sel_word;
    reg signed [DW+1:0] req;
    reg below_floor;
    reg [DW-1:0] tgt_next;

    always @* begin
        case (MARGIN_SEL)
            `MARGIN_HIGH_SEL: sel_word = w_mhigh;
            `MARGIN_LOW_SEL: sel_word = w_mlow;
            default: sel_word = NOMINAL_CMD;
        endcase
        req = $signed({2'b00, sel_word}) + $signed({{2{TRIM_CMD[DW-1]}}, TRIM_CMD});
        below_floor = req < $signed({2'b00, w_floor});
        if (below_floor) begin
            tgt_next = w_floor;
        end else if (req[DW]) begin
            tgt_next = {DW{1'b1}};
        end else begin
            tgt_next = req[DW-1:0];
        end
    end

    always @(posedge CLK) begin
        if (!RSTN) begin
            VOUT_TARGET <= `WORD_RESET;
            FLOOR_WARN <= 1'b0;
            MODE_ERR <= 1'b0;
        end else begin
            VOUT_TARGET <= tgt_next;
            // set wins over a clear in the same cycle
            FLOOR_WARN <= below_floor | (FLOOR_WARN & ~CLR_WARN);
            MODE_ERR <= (OUT_MODE[`MODE_SEL_HI:`MODE_SEL_LO] != `MODE_SEL_LINEAR) |
                        (OUT_MODE[`MODE_EXP_HI:0] != `MODE_EXP_FIXED);
        end
    end

    // ***************************************************************
    // slew-limited setpoint
    // ***************************************************************
    // one lsb per cycle at most: rates above about 122 V/ms are capped
    wire [FW-1:0] slew_q8 = lin_fix(w_slew);
    wire [FW-1:0] slew_inc = slew_q8 * `SLEW_LSB_PER_VOLT / (1 << `LIN_FRAC);
    reg [FW-1:0] slew_acc_reg;
    wire [FW-1:0] slew_sum = slew_acc_reg + slew_inc;

    always @(posedge CLK) begin
        if (!RSTN) begin
            VOUT_SETPOINT <= `WORD_RESET;
            slew_acc_reg <= {FW{1'b0}};
        end else if (slew_q8[FW-1] || slew_q8 == {FW{1'b0}}) begin
            VOUT_SETPOINT <= VOUT_TARGET;
            slew_acc_reg <= {FW{1'b0}};
        end else if (VOUT_SETPOINT == VOUT_TARGET) begin
            slew_acc_reg <= {FW{1'b0}};
        end else if (slew_sum >= `CYC_PER_RATE_TIME) begin
            slew_acc_reg <= slew_sum - `CYC_PER_RATE_TIME;
            if (VOUT_SETPOINT < VOUT_TARGET) begin
                VOUT_SETPOINT <= VOUT_SETPOINT + 16'h0001;
            end else begin
                VOUT_SETPOINT <= VOUT_SETPOINT - 16'h0001;
            end
        end else begin
            slew_acc_reg <= slew_sum;
        end
    end

    // ***************************************************************
    // input thresholds, limits and readings
    // ***************************************************************
    wire signed [FW-1:0] vin_fix = lin_fix(MEAS_VIN);
    wire signed [FW-1:0] von_fix = lin_fix(w_von);
    wire signed [FW-1:0] voff_fix = lin_fix(w_voff);
    wire [FW-1:0] iout_sum = lin_fix(IOUT_RAW) + lin_fix(w_iofs);
    wire [FW-1:0] freq_fix = lin_fix(w_freq);
    wire [FW-1:0] droop_fix = lin_fix(w_droop);
    wire [FW-1:0] duty_fix = lin_fix(w_duty);

    always @(posedge CLK) begin
        if (!RSTN) begin
            OV_FAULT <= 1'b0;
            IOUT_REPORT <= 32'h00000000;
            LOAD_LINE_Q8 <= 32'h00000000;
            DUTY_MAX_Q8 <= 32'h00000000;
            FREQ_KHZ <= `WORD_RESET;
        end else begin
            OV_FAULT <= MEAS_VOUT > w_ovl;
            IOUT_REPORT <= iout_sum[31:0];
            LOAD_LINE_Q8 <= droop_fix[31:0];
            DUTY_MAX_Q8 <= duty_fix[31:0];
            FREQ_KHZ <= freq_fix[`LIN_FRAC +: DW];
        end
    end

    // ***************************************************************
    // conversion enable
    // ***************************************************************
    localparam [1:0] ST_IDLE = 2'h1;
    localparam [1:0] ST_RUN = 2'h2;
    reg [1:0] run_state_reg;
    reg [1:0] run_state_next;

    // hysteresis: the off threshold is only looked at once running
    always @* begin
        case (run_state_reg)
            ST_IDLE: begin
                if (vin_fix >= von_fix) begin
                    run_state_next = ST_RUN;
                end else begin
                    run_state_next = ST_IDLE;
                end
            end
            ST_RUN: begin
                if (vin_fix <= voff_fix) begin
                    run_state_next = ST_IDLE;
                end else begin
                    run_state_next = ST_RUN;
                end
            end
            default: run_state_next = ST_IDLE;
        endcase
    end

    always @(posedge CLK) begin
        if (!RSTN) begin
            run_state_reg <= ST_IDLE;
            CONVERT_EN <= 1'b0;
        end else begin
            run_state_reg <= run_state_next;
            CONVERT_EN <= run_state_next == ST_RUN;
        end
    end

    // ***************************************************************
    // phase interleave
    // ***************************************************************
    wire [3:0] il_cnt = w_il[`IL_COUNT_HI:`IL_COUNT_LO];
    wire [3:0] il_pos = w_il[`IL_POS_HI:`IL_POS_LO];
    wire il_on = SYNC_LOCKED && il_cnt > 4'h1;
    // a zero count divides by zero; il_on masks that result away
    wire [31:0] phase_wide = ({28'h0000000, il_pos} * `PHASE_STEPS) / {28'h0000000, il_cnt};
    wire [11:0] phase_full = phase_wide[11:0];

    always @(posedge CLK) begin
        if (!RSTN) begin
            GROUP_ID <= 4'h0;
            GROUP_SIZE <= 4'h0;
            RAIL_POS <= 4'h0;
            INTERLEAVE_EN <= 1'b0;
            PHASE_OFFSET <= 8'h00;
        end else begin
            GROUP_ID <= w_il[`IL_GROUP_HI:`IL_GROUP_LO];
            GROUP_SIZE <= il_cnt;
            RAIL_POS <= il_pos;
            INTERLEAVE_EN <= il_on;
            // position zero sits on the shared clock edge itself
            PHASE_OFFSET <= il_on ? phase_full[7:0] : 8'h00;
        end
    end
endmodule

// File: cocr_top_properties.sv
// checker for the configuration bank, watching only the top module's ports.
// assumes known command codes on every write strobe.
`timescale 1ns/10ps
module cocr_chk (
    input wire CLK,
    input wire RSTN,
    input wire [7:0] CMD_CODE,
    input wire [15:0] WR_DATA,
    input wire WR_STB,
    input wire RD_STB,
    input wire RD_VALID,
    input wire CMD_UNSUP,
    input wire [15:0] MEAS_VOUT,
    input wire SYNC_LOCKED,
    input wire CLR_WARN,
    input wire [15:0] VOUT_TARGET,
    input wire FLOOR_WARN,
    input wire CONVERT_EN,
    input wire OV_FAULT,
    input wire [3:0] GROUP_ID,
    input wire [3:0] GROUP_SIZE,
    input wire [3:0] RAIL_POS,
    input wire INTERLEAVE_EN
);
    // ****************************************
    // shadow words
    // ****************************************
    reg [15:0] floor_reg;
    reg [15:0] ov_reg;
    reg [15:0] il_reg;
    reg [3:0] quiet_reg;
    wire settled;
    // outputs lag the bank by up to two cycles, so judge only after a quiet spell
    assign settled = quiet_reg >= 4'h3;
    always @(posedge CLK) begin
        if (!RSTN) begin
            floor_reg <= 16'h0000;
            ov_reg <= 16'h0000;
            il_reg <= 16'h0000;
            quiet_reg <= 4'h0;
        end else begin
            if (WR_STB && CMD_CODE == 8'h2B) floor_reg <= WR_DATA;
            if (WR_STB && CMD_CODE == 8'h40) ov_reg <= WR_DATA;
            if (WR_STB && CMD_CODE == 8'h37) il_reg <= WR_DATA;
            if (WR_STB) quiet_reg <= 4'h0;
            else if (quiet_reg != 4'hF) quiet_reg <= quiet_reg + 4'h1;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // ****************************************
    // properties
    // ****************************************
    a_read_answer: assert property (RD_STB |=> RD_VALID)
        else $error("read not answered next cycle");
    a_valid_cause: assert property (RD_VALID |-> $past(RD_STB))
        else $error("read answer without request");
    a_known_code: assert property ((WR_STB || RD_STB) && CMD_CODE == 8'h2B |-> !CMD_UNSUP)
        else $error("known code refused");
    a_target_floor: assert property (settled |-> VOUT_TARGET >= floor_reg)
        else $error("target under floor");
    a_warn_hold: assert property (FLOOR_WARN && !CLR_WARN |=> FLOOR_WARN)
        else $error("warning dropped");
    a_ov_level: assert property (settled |-> OV_FAULT == ($past(MEAS_VOUT) > ov_reg))
        else $error("overvoltage flag wrong");
    a_group_field: assert property (settled |-> GROUP_ID == il_reg[11:8])
        else $error("group field wrong");
    a_count_field: assert property (settled |-> GROUP_SIZE == il_reg[7:4])
        else $error("count field wrong");
    a_pos_field: assert property (settled |-> RAIL_POS == il_reg[3:0])
        else $error("position field wrong");
    a_sync_gate: assert property (!$past(SYNC_LOCKED) |-> !INTERLEAVE_EN)
        else $error("interleave without shared clock");
    c_read: cover property (RD_VALID);
    c_warn: cover property ($rose(FLOOR_WARN));
    c_lock: cover property ($rose(INTERLEAVE_EN));
    c_conv: cover property ($rose(CONVERT_EN));
endmodule

// File: cocr_host.sv
// host model: issues one-word command requests to the bank.
// assumes the shared clock; drives at the falling edge.
`timescale 1ns/10ps
module cocr_host (
    input wire CLK,
    input wire [15:0] RD_DATA,
    input wire RD_VALID,
    input wire CMD_UNSUP,
    output reg [7:0] CMD_CODE,
    output reg [15:0] WR_DATA,
    output reg WR_STB,
    output reg RD_STB
);
    // ****************************************
    // requests
    // ****************************************
    reg unsup;
    initial begin
        CMD_CODE = 8'h00;
        WR_DATA = 16'h0000;
        WR_STB = 1'b0;
        RD_STB = 1'b0;
        unsup = 1'b0;
    end
    // released lines show the inverse so a stale value cannot pass
    task wr(input [7:0] c, input [15:0] d);
        begin
            @(negedge CLK);
            CMD_CODE = c;
            WR_DATA = d;
            WR_STB = 1'b1;
            #1 unsup = CMD_UNSUP;
            @(negedge CLK);
            WR_STB = 1'b0;
            CMD_CODE = ~c;
            WR_DATA = ~d;
        end
    endtask
    task rd(input [7:0] c, output [15:0] d, output v);
        begin
            @(negedge CLK);
            CMD_CODE = c;
            RD_STB = 1'b1;
            #1 unsup = CMD_UNSUP;
            @(negedge CLK);
            RD_STB = 1'b0;
            CMD_CODE = ~c;
            v = RD_VALID;
            d = RD_DATA;
        end
    endtask
endmodule

// File: converter_output_config_regs_test.sv
// testbench of the configuration bank with a host model on the command side.
// assumes the checker file is compiled first.
`timescale 1ns/10ps
`define CHK(n, e, g) \
    begin \
        comparisons = comparisons + 1; \
        if ((g) !== (e)) begin \
            errors = errors + 1; \
            $display("BAD %s exp %h got %h", n, e, g); \
        end \
    end
module converter_output_config_regs_test;
    // ****************************************
    // bench
    // ****************************************
    localparam [95:0] CODES = 96'h25262728_2B323335_36373940;
    reg clk = 1'b0, rstn = 1'b0, sync = 1'b0, clrw = 1'b0, v;
    reg [7:0] omode = 8'h15;
    reg [1:0] msel = 2'b00;
    reg [15:0] nom = 16'h0000, trim = 16'h0000, vin = 16'h0000, vout = 16'h0000;
    reg [15:0] iraw = 16'h0000, d, e;
    wire [7:0] code, poff;
    wire [15:0] wdata, rdata, vset, vtgt, freq;
    wire [31:0] irep, ll, duty;
    wire [3:0] gid, gsz, pos;
    wire wstb, rstb, rvalid, unsup, fwarn, merr, conv, ovf, ilen;
    integer errors = 0, comparisons = 0, cycles = 0;
    always #2 clk = ~clk;
    cocr_host h (.CLK(clk), .RD_DATA(rdata), .RD_VALID(rvalid), .CMD_UNSUP(unsup),
        .CMD_CODE(code), .WR_DATA(wdata), .WR_STB(wstb), .RD_STB(rstb));
    cocr_top dut (.CLK(clk), .RSTN(rstn), .CMD_CODE(code), .WR_DATA(wdata), .WR_STB(wstb),
        .RD_STB(rstb), .RD_DATA(rdata), .RD_VALID(rvalid), .CMD_UNSUP(unsup),
        .OUT_MODE(omode), .NOMINAL_CMD(nom), .TRIM_CMD(trim), .MARGIN_SEL(msel),
        .MEAS_VIN(vin), .MEAS_VOUT(vout), .IOUT_RAW(iraw), .SYNC_LOCKED(sync),
        .CLR_WARN(clrw), .VOUT_SETPOINT(vset), .VOUT_TARGET(vtgt), .FLOOR_WARN(fwarn),
        .MODE_ERR(merr), .CONVERT_EN(conv), .OV_FAULT(ovf), .IOUT_REPORT(irep),
        .LOAD_LINE_Q8(ll), .DUTY_MAX_Q8(duty), .FREQ_KHZ(freq), .GROUP_ID(gid),
        .GROUP_SIZE(gsz), .RAIL_POS(pos), .INTERLEAVE_EN(ilen), .PHASE_OFFSET(poff));
    task cyc(input integer n);
        repeat (n) @(negedge clk);
    endtask
    task print_verdict;
        begin
            if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            errors = errors + 1;
            print_verdict;
        end
    end
    task t_regs;
        integer i;
        reg [7:0] c;
        begin
            for (i = 0; i < 12; i = i + 1) begin
                c = CODES[95-8*i -: 8];
                e = {c, ~c};
                h.rd(c, d, v);
                `CHK("reset word", 16'h0000, d)
                h.wr(c, e);
                h.rd(c, d, v);
                `CHK("valid", 1'b1, v)
                `CHK("word", e, d)
            end
            h.wr(8'h30, 16'h1234);
            `CHK("unmapped wr", 1'b1, h.unsup)
            h.rd(8'h30, d, v);
            `CHK("unmapped rd", 16'h0000, d)
        end
    endtask
    task t_floor;
        begin
            nom = 16'h5000;
            h.wr(8'h2B, 16'h6000);
            cyc(3);
            `CHK("clamp", 16'h6000, vtgt)
            `CHK("warn", 1'b1, fwarn)
            `CHK("no fault", 1'b0, ovf)
            clrw = 1'b1;
            nom = 16'h6800;
            cyc(1);
            clrw = 1'b0;
            cyc(2);
            `CHK("warn clear", 1'b0, fwarn)
            trim = 16'hF000;
            cyc(3);
            `CHK("trim clamp", 16'h6000, vtgt)
            trim = 16'h0000;
            msel = 2'b10;
            h.wr(8'h26, 16'h7000);
            cyc(3);
            `CHK("margin low", 16'h7000, vtgt)
            msel = 2'b01;
            h.wr(8'h25, 16'h7400);
            cyc(3);
            `CHK("margin high", 16'h7400, vtgt)
            h.wr(8'h2B, 16'h9000);
            cyc(3);
            `CHK("floor unsigned", 16'h9000, vtgt)
            msel = 2'b00;
            h.wr(8'h2B, 16'h0000);
        end
    endtask
    task t_limits;
        begin
            h.wr(8'h40, 16'h6000);
            vout = 16'h6000;
            cyc(3);
            `CHK("ov equal", 1'b0, ovf)
            vout = 16'h8000;
            cyc(2);
            `CHK("ov above", 1'b1, ovf)
            vout = 16'h0000;
            h.wr(8'h35, 16'hF850);
            h.wr(8'h36, 16'h0020);
            vin = 16'h0010;
            cyc(3);
            `CHK("off", 1'b0, conv)
            vin = 16'h0027;
            cyc(3);
            `CHK("under on", 1'b0, conv)
            vin = 16'h0028;
            cyc(3);
            `CHK("on", 1'b1, conv)
            vin = 16'h0021;
            cyc(3);
            `CHK("held on", 1'b1, conv)
            vin = 16'h0020;
            cyc(3);
            `CHK("stop", 1'b0, conv)
        end
    endtask
    task t_decode;
        begin
            h.wr(8'h28, 16'hF803);
            h.wr(8'h32, 16'h005A);
            h.wr(8'h33, 16'h08C8);
            h.wr(8'h39, 16'h07FF);
            iraw = 16'h000A;
            omode = 8'h35;
            cyc(3);
            `CHK("load line", 32'h00000180, ll)
            `CHK("duty", 32'h00005A00, duty)
            `CHK("freq", 16'h0190, freq)
            `CHK("iout", 32'h00000900, irep)
            `CHK("mode", 1'b1, merr)
            omode = 8'h15;
            sync = 1'b1;
            h.wr(8'h37, 16'h0A42);
            cyc(3);
            `CHK("group", 4'hA, gid)
            `CHK("size", 4'h4, gsz)
            `CHK("position", 4'h2, pos)
            `CHK("locked", 1'b1, ilen)
            `CHK("offset", 8'h80, poff)
            `CHK("mode ok", 1'b0, merr)
            sync = 1'b0;
            cyc(3);
            `CHK("unlocked", 1'b0, ilen)
            sync = 1'b1;
            h.wr(8'h37, 16'h0F30);
            cyc(3);
            `CHK("lead on", 1'b1, ilen)
            `CHK("lead", 8'h00, poff)
        end
    endtask
    task t_slew;
        begin
            h.wr(8'h27, 16'h0000);
            nom = 16'h6000;
            cyc(3);
            `CHK("jump", 16'h6000, vset)
            h.wr(8'h27, 16'h0001);
            nom = 16'h6010;
            cyc(20);
            `CHK("ramping", 1'b1, vset < 16'h6010)
            cyc(2000);
            `CHK("ramp done", 16'h6010, vset)
        end
    endtask
    initial begin
        cyc(8);
        rstn = 1'b1;
        t_regs;
        t_floor;
        t_limits;
        t_decode;
        t_slew;
        print_verdict;
    end
endmodule
bind cocr_top cocr_chk chk (.CLK(CLK), .RSTN(RSTN), .CMD_CODE(CMD_CODE), .WR_DATA(WR_DATA),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_VALID(RD_VALID), .CMD_UNSUP(CMD_UNSUP),
    .MEAS_VOUT(MEAS_VOUT), .SYNC_LOCKED(SYNC_LOCKED), .CLR_WARN(CLR_WARN),
    .VOUT_TARGET(VOUT_TARGET), .FLOOR_WARN(FLOOR_WARN), .CONVERT_EN(CONVERT_EN),
    .OV_FAULT(OV_FAULT), .GROUP_ID(GROUP_ID), .GROUP_SIZE(GROUP_SIZE), .RAIL_POS(RAIL_POS),
    .INTERLEAVE_EN(INTERLEAVE_EN));
